/* rtl/opsc_top.sv */
// Command decoder for pump, display, page, scan, offset and clock settings.
`timescale 1ns/10ps
module opsc_top
  import opsc_pkg::*;
#(
  parameter int OSC_CYCLES   = OSC_NOM_CYCLES,
  parameter int CLKS_PER_ROW = 4
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_b_i,
  input  wire opsc_host_t        host_i,
  input  wire logic [OFFS_W-1:0] mux_last_i,
  output opsc_cfg_t              cfg_o,
  output logic [PAGE_W-1:0]      page_o,
  output logic                   mem_wr_o,
  output logic [7:0]             mem_wdata_o,
  output logic                   sleep_o,
  output logic                   pump_run_o,
  output logic                   ext_supply_req_o,
  output logic                   osc_run_o,
  output logic                   panel_oe_b_o,
  output logic                   display_clock_tick_o,
  output logic [OFFS_W-1:0]      first_common_row_o,
  output logic [OFFS_W-1:0]      common_row_o,
  output logic [OFFS_W-1:0]      display_line_o,
  output logic                   frame_start_o,
  output logic                   cmd_taken_o,
  output logic                   cmd_undef_o
);

  // --------------------------------------------------------------------
  // Decoder state
  // --------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PUMP = 5'b00010,
    ST_OFFS = 5'b00100,
    ST_CLK  = 5'b01000,
    ST_SKIP = 5'b10000
  } opsc_state_t;

  opsc_state_t st_r;
  opsc_state_t st_nxt;
  opsc_cfg_t   cfg_r;
  logic        cmd_wr;
  logic        known_single;
  logic        foreign_prefix;

  // Matches a command byte against a code after masking out argument bits.
  function automatic logic opsc_hit(input logic [7:0] b,
                                    input logic [7:0] code,
                                    input logic [7:0] mask);
    opsc_hit = (b & mask) == (code & mask);
  endfunction

  // Writes with the select low are commands; high means display data.
  assign cmd_wr = host_i.wr && !host_i.sel; // R20

  // Codes served by other blocks: single codes are kept so they are not flagged undefined,
  // foreign prefixes so the prefix tracking stays in step with the host's byte stream.
  always_comb begin
    known_single = 1'b0;
    if (host_i.data[7:5] == 3'b000) begin
      known_single = 1'b1;
    end else if (opsc_hit(host_i.data, 8'h30, 8'hfc)) begin
      known_single = 1'b1;
    end else if (host_i.data[7:6] == 2'b01) begin
      known_single = 1'b1;
    end else if (opsc_hit(host_i.data, 8'ha0, 8'hf8)) begin
      known_single = 1'b1;
    end else if (host_i.data == 8'he0 || host_i.data == 8'hee ||
                 host_i.data == 8'he3) begin
      known_single = 1'b1;
    end
  end

  assign foreign_prefix = (host_i.data == 8'h81) || (host_i.data == 8'ha8) ||
                          (host_i.data == 8'hd9) || (host_i.data == 8'hda) ||
                          (host_i.data == 8'hdb);

  // --------------------------------------------------------------------
  // Prefix sequencing
  // --------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: begin
        if (cmd_wr) begin
          if (host_i.data == CMD_PUMP_PREFIX) begin // R1
            st_nxt = ST_PUMP;
          end else if (host_i.data == CMD_OFFS_PREFIX) begin // R15
            st_nxt = ST_OFFS;
          end else if (host_i.data == CMD_CLK_PREFIX) begin // R17
            st_nxt = ST_CLK;
          end else if (foreign_prefix) begin
            st_nxt = ST_SKIP;
          end
        end
      end
      ST_PUMP, ST_OFFS, ST_CLK, ST_SKIP: begin
        if (cmd_wr) begin // R20
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Operating settings
  // --------------------------------------------------------------------
  // Nothing here looks at the sleep state, so settings live through it.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_r.pump_armed <= RST_PUMP_ARMED;
      cfg_r.disp_on    <= RST_DISP_ON;
      cfg_r.scan_rev   <= RST_SCAN_REV;
      cfg_r.offset     <= RST_OFFSET;
      cfg_r.div_nib    <= RST_DIV_NIB;
      cfg_r.trim       <= RST_TRIM;
    end else if (cmd_wr) begin // R8
      if (st_r == ST_PUMP) begin
        // The pump byte only counts right after its prefix.
        if (opsc_hit(host_i.data, CMD_PUMP_DATA, MASK_BIT0)) begin // R1
          cfg_r.pump_armed <= host_i.data[0]; // R2
        end
      end else if (st_r == ST_OFFS) begin
        cfg_r.offset <= host_i.data[OFFS_W-1:0]; // R15
      end else if (st_r == ST_CLK) begin
        cfg_r.div_nib <= host_i.data[NIB_W-1:0]; // R17
        cfg_r.trim    <= host_i.data[7:4]; // R18
      end else if (st_r == ST_IDLE) begin
        if (opsc_hit(host_i.data, CMD_DISP, MASK_BIT0)) begin
          cfg_r.disp_on <= host_i.data[0]; // R4
        end else if (opsc_hit(host_i.data, CMD_SCAN, MASK_SCAN)) begin
          cfg_r.scan_rev <= host_i.data[SCAN_DIR_BIT]; // R13 R14
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Page register
  // --------------------------------------------------------------------
  // The page only steers host accesses; the scanner never reads it.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      page_o <= RST_PAGE;
    end else if (cmd_wr && st_r == ST_IDLE &&
                 opsc_hit(host_i.data, CMD_PAGE, MASK_PAGE)) begin
      page_o <= host_i.data[PAGE_W-1:0]; // R10 R11
    end
  end

  // --------------------------------------------------------------------
  // Host memory path
  // --------------------------------------------------------------------
  // Data writes pass regardless of sleep, since the host may load the
  // frame before waking the panel.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_wr_o    <= 1'b0;
      mem_wdata_o <= 8'h00;
    end else begin
      mem_wr_o <= host_i.wr && host_i.sel; // R9
      if (host_i.wr && host_i.sel) begin
        mem_wdata_o <= host_i.data;
      end
    end
  end

  // --------------------------------------------------------------------
  // Command status
  // --------------------------------------------------------------------
  // Undefined codes are flagged for debug only; they change no setting.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_taken_o <= 1'b0;
      cmd_undef_o <= 1'b0;
    end else begin
      cmd_taken_o <= cmd_wr;
      cmd_undef_o <= 1'b0;
      if (cmd_wr) begin
        if (st_r == ST_PUMP) begin
          cmd_undef_o <= !opsc_hit(host_i.data, CMD_PUMP_DATA, MASK_BIT0);
        end else if (st_r == ST_IDLE) begin
          cmd_undef_o <= !(known_single || foreign_prefix ||
            host_i.data == CMD_PUMP_PREFIX ||
            host_i.data == CMD_OFFS_PREFIX ||
            host_i.data == CMD_CLK_PREFIX ||
            opsc_hit(host_i.data, CMD_DISP, MASK_BIT0) ||
            opsc_hit(host_i.data, CMD_PAGE, MASK_PAGE) ||
            opsc_hit(host_i.data, CMD_SCAN, MASK_SCAN)); // R12
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Power state
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sleep_o          <= 1'b1;
      pump_run_o       <= 1'b0;
      ext_supply_req_o <= 1'b0;
      osc_run_o        <= 1'b0;
      panel_oe_b_o     <= 1'b1;
    end else begin
      sleep_o          <= !cfg_r.disp_on; // R3 R5
      osc_run_o        <= cfg_r.disp_on; // R6
      pump_run_o       <= cfg_r.disp_on && cfg_r.pump_armed; // R3 R6
      ext_supply_req_o <= cfg_r.disp_on && !cfg_r.pump_armed; // R3
      panel_oe_b_o     <= !cfg_r.disp_on; // R7
    end
  end

  assign cfg_o              = cfg_r;
  assign first_common_row_o = cfg_r.offset; // R16

  // --------------------------------------------------------------------
  // Display timing
  // --------------------------------------------------------------------
  opsc_clkgen #(
    .OSC_CYCLES (OSC_CYCLES)
  ) u_clkgen (
    .ref_clk_i            (ref_clk_i),
    .rst_b_i              (rst_b_i),
    .run_i                (osc_run_o),
    .trim_i               (cfg_r.trim),
    .div_nib_i            (cfg_r.div_nib),
    .osc_tick_o           (),
    .display_clock_tick_o (display_clock_tick_o)
  );

  opsc_scan #(
    .CLKS_PER_ROW (CLKS_PER_ROW)
  ) u_scan (
    .ref_clk_i      (ref_clk_i),
    .rst_b_i        (rst_b_i),
    .tick_i         (display_clock_tick_o),
    .mux_last_i     (mux_last_i),
    .scan_rev_i     (cfg_r.scan_rev),
    .offset_i       (cfg_r.offset),
    .common_row_o   (common_row_o),
    .display_line_o (display_line_o),
    .frame_start_o  (frame_start_o)
  );

endmodule

/* pkg/opsc_pkg.sv */
// Package with constants and types for the OLED power, scan and clock commands.
// What this block does
// R1: Host sends pump prefix then data, display off
// R2: Pump data bit 0 disables or arms pump
// R3: Display and pump state choose sleep or supply
// R4: AEH/AFH set display off/on, off at reset
// R5: Display off enters sleep
// R6: Sleep halts oscillator and pump
// R7: Sleep puts segment and common outputs Hi-Z
// R8: Sleep keeps memory and all settings
// R9: Memory stays host accessible during sleep
// R10: B0H-B7H load page register with 0-7
// R11: Page register never changes displayed image
// R12: Host sends only defined command codes
// R13: C0H/C8H bit 3 selects common scan direction
// R14: Scan direction change acts immediately
// R15: D3H prefix, next byte bits 5..0 offset
// R16: Offset maps start line onto common row mod 64
// R17: D5H prefix, low nibble plus one divides
// R18: High nibble trims oscillator in 5% steps
// R19: Display clock is divided oscillator
// R20: Commands are writes with select low; prefix
package opsc_pkg;

  // ----------------------------------------------------------------------
  // Command codes and masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_PUMP_PREFIX = 8'had;
  localparam logic [7:0] CMD_PUMP_DATA   = 8'h8a;
  localparam logic [7:0] CMD_DISP        = 8'hae;
  localparam logic [7:0] CMD_PAGE        = 8'hb0;
  localparam logic [7:0] CMD_SCAN        = 8'hc0;
  localparam logic [7:0] CMD_OFFS_PREFIX = 8'hd3;
  localparam logic [7:0] CMD_CLK_PREFIX  = 8'hd5;
  localparam logic [7:0] MASK_BIT0       = 8'hfe;
  localparam logic [7:0] MASK_PAGE       = 8'hf8;
  localparam logic [7:0] MASK_SCAN       = 8'hf0;
  localparam int         SCAN_DIR_BIT    = 3;
  localparam int         OFFS_W          = 6;
  localparam int         PAGE_W          = 3;
  localparam int         NIB_W           = 4;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic              RST_PUMP_ARMED = 1'b1;
  localparam logic              RST_DISP_ON    = 1'b0;
  localparam logic              RST_SCAN_REV   = 1'b0;
  localparam logic [OFFS_W-1:0] RST_OFFSET     = 6'h00;
  localparam logic [NIB_W-1:0]  RST_DIV_NIB    = 4'h0;
  localparam logic [NIB_W-1:0]  RST_TRIM       = 4'h5;
  localparam logic [PAGE_W-1:0] RST_PAGE       = 3'h0;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int REF_CLK_HZ     = 20_000_000;
  localparam int OSC_NOM_HZ     = 400_000;
  localparam int OSC_NOM_CYCLES = REF_CLK_HZ / OSC_NOM_HZ;
  // Trim code t gives (TRIM_BASE + t) / TRIM_DEN of nominal frequency.
  localparam int TRIM_BASE      = 15;
  localparam int TRIM_DEN       = 20;
  localparam int COM_ROWS       = 64;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              sel;
    logic [7:0]        data;
  } opsc_host_t;

  typedef struct packed {
    logic              pump_armed;
    logic              disp_on;
    logic              scan_rev;
    logic [OFFS_W-1:0] offset;
    logic [NIB_W-1:0]  div_nib;
    logic [NIB_W-1:0]  trim;
  } opsc_cfg_t;

endpackage

/* rtl/opsc_clkgen.sv */
// Trimmed oscillator model and display clock divider.
`timescale 1ns/10ps
module opsc_clkgen
  import opsc_pkg::*;
#(
  parameter int OSC_CYCLES = OSC_NOM_CYCLES
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             run_i,
  input  wire logic [NIB_W-1:0] trim_i,
  input  wire logic [NIB_W-1:0] div_nib_i,
  output logic                  osc_tick_o,
  output logic                  display_clock_tick_o
);

  localparam int          ACC_W   = 16;
  localparam logic [ACC_W-1:0] ACC_TOP =
    ACC_W'(TRIM_DEN * OSC_CYCLES);

  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;
  logic [NIB_W-1:0] div_cnt_r;

  // --------------------------------------------------------------------
  // Oscillator
  // --------------------------------------------------------------------
  // A phase accumulator keeps the trimmed frequency exact on average.
  assign acc_nxt = acc_r + ACC_W'(TRIM_BASE) + ACC_W'(trim_i); // R18

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_r      <= '0;
      osc_tick_o <= 1'b0;
    end else if (!run_i) begin // R6
      osc_tick_o <= 1'b0;
    end else if (acc_nxt >= ACC_TOP) begin
      acc_r      <= acc_nxt - ACC_TOP;
      osc_tick_o <= 1'b1;
    end else begin
      acc_r      <= acc_nxt;
      osc_tick_o <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Divider
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_cnt_r            <= '0;
      display_clock_tick_o <= 1'b0;
    end else if (osc_tick_o && run_i) begin
      if (div_cnt_r >= div_nib_i) begin // R17 R19
        div_cnt_r            <= '0;
        display_clock_tick_o <= 1'b1;
      end else begin
        div_cnt_r            <= div_cnt_r + 4'h1;
        display_clock_tick_o <= 1'b0;
      end
    end else begin
      display_clock_tick_o <= 1'b0;
    end
  end

endmodule

/* rtl/opsc_scan.sv */
// Common row scanner with direction and display offset.
`timescale 1ns/10ps
module opsc_scan
  import opsc_pkg::*;
#(
  parameter int CLKS_PER_ROW = 4
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              tick_i,
  input  wire logic [OFFS_W-1:0] mux_last_i,
  input  wire logic              scan_rev_i,
  input  wire logic [OFFS_W-1:0] offset_i,
  output logic [OFFS_W-1:0]      common_row_o,
  output logic [OFFS_W-1:0]      display_line_o,
  output logic                   frame_start_o
);

  logic [7:0]        clk_cnt_r;
  logic [OFFS_W-1:0] row_r;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clk_cnt_r     <= '0;
      row_r         <= '0;
      frame_start_o <= 1'b0;
    end else if (tick_i) begin
      frame_start_o <= 1'b0;
      if (clk_cnt_r == 8'(CLKS_PER_ROW - 1)) begin
        clk_cnt_r <= '0;
        if (row_r >= mux_last_i) begin
          row_r         <= '0;
          frame_start_o <= 1'b1;
        end else begin
          row_r <= row_r + 6'h01;
        end
      end else begin
        clk_cnt_r <= clk_cnt_r + 8'h01;
      end
    end else begin
      frame_start_o <= 1'b0;
    end
  end

  // Direction and offset are used live, so a change shows at once.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      common_row_o   <= '0;
      display_line_o <= '0;
    end else begin
      common_row_o   <= scan_rev_i ? (mux_last_i - row_r) : row_r; // R13 R14
      display_line_o <= row_r - offset_i; // R16
    end
  end

endmodule

/* testbench/opsc_properties.sv */
// Checker of port-level timing rules for the command decoder.
`timescale 1ns/10ps
module opsc_properties
  import opsc_pkg::*;
#(
  parameter int OSC_CYCLES   = OSC_NOM_CYCLES,
  parameter int CLKS_PER_ROW = 4
) (
  input wire logic              ref_clk_i,
  input wire logic              rst_b_i,
  input wire opsc_host_t        host_i,
  input wire opsc_cfg_t         cfg_o,
  input wire logic [PAGE_W-1:0] page_o,
  input wire logic              mem_wr_o,
  input wire logic [7:0]        mem_wdata_o,
  input wire logic              sleep_o,
  input wire logic              pump_run_o,
  input wire logic              ext_supply_req_o,
  input wire logic              osc_run_o,
  input wire logic              panel_oe_b_o,
  input wire logic              display_clock_tick_o,
  input wire logic [OFFS_W-1:0] first_common_row_o
);
  // ----------------------------------------------------------------------
  // Prefix tracking
  // ----------------------------------------------------------------------
  logic       cmd;
  logic [7:0] pre_r;
  assign cmd = host_i.wr && !host_i.sel;
  // An argument byte must not be mistaken for a command, so the pending
  // prefix is followed here, foreign prefixes included.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_r <= 8'h00;
    end else if (cmd) begin
      pre_r <= (pre_r == 8'h00 && host_i.data inside {8'had, 8'hd3,
                8'hd5, 8'h81, 8'ha8, 8'hd9, 8'hda, 8'hdb}) ?
               host_i.data : 8'h00;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  pump_set_a: assert property (cmd && pre_r == 8'had
    && host_i.data[7:1] == 7'h45 |=> cfg_o.pump_armed == $past(host_i.data[0]))
    else $error("pump enable not loaded");
  disp_sleep_a: assert property ($changed(cfg_o.disp_on)
    |=> sleep_o == !$past(cfg_o.disp_on)) else $error("sleep not following");
  sleep_state_a: assert property (sleep_o
    |-> panel_oe_b_o && !osc_run_o && !pump_run_o) else $error("sleep active");
  ext_supply_a: assert property ((cfg_o.disp_on && !cfg_o.pump_armed)[*2]
    |-> ext_supply_req_o && !pump_run_o) else $error("ext supply missing");
  page_load_a: assert property (cmd && pre_r == 8'h00
    && host_i.data[7:3] == 5'h16 |=> page_o == $past(host_i.data[2:0]))
    else $error("page not loaded");
  scan_load_a: assert property (cmd && pre_r == 8'h00
    && host_i.data[7:4] == 4'hc
    |=> cfg_o.scan_rev == $past(host_i.data[3])) else $error("scan not set");
  offs_load_a: assert property (cmd && pre_r == 8'hd3 |=>
    first_common_row_o == $past(host_i.data[5:0])
    && cfg_o.offset == $past(host_i.data[5:0])) else $error("offset not set");
  clk_load_a: assert property (cmd && pre_r == 8'hd5
    |=> {cfg_o.trim, cfg_o.div_nib} == $past(host_i.data))
    else $error("clock setting not loaded");
  mem_access_a: assert property (host_i.wr && host_i.sel
    |=> mem_wr_o && mem_wdata_o == $past(host_i.data))
    else $error("data write lost");
  tick_halt_a: assert property (sleep_o[*3]
    |-> !display_clock_tick_o) else $error("tick during sleep");
  cover property (cmd && pre_r == 8'hd5);
  cover property ($rose(cfg_o.disp_on));
  cover property (display_clock_tick_o && !sleep_o);
endmodule
bind opsc_top opsc_properties #(
  .OSC_CYCLES(OSC_CYCLES),
  .CLKS_PER_ROW(CLKS_PER_ROW)
) chk (
  .ref_clk_i, .rst_b_i, .host_i, .cfg_o, .page_o, .mem_wr_o, .mem_wdata_o,
  .sleep_o, .pump_run_o, .ext_supply_req_o, .osc_run_o, .panel_oe_b_o,
  .display_clock_tick_o, .first_common_row_o
);

/* testbench/opsc_host_model.sv */
// Host model that writes command and data bytes into the decoder.
`timescale 1ns/10ps
module opsc_host_model
  import opsc_pkg::*;
(
  input  wire logic ref_clk_i,
  output opsc_host_t host_o
);
  initial host_o = '0;
  // One byte per cycle, held through the rising edge that takes it.
  task automatic send(input logic sel, input logic [7:0] data);
    @(negedge ref_clk_i);
    host_o = '{wr: 1'b1, sel: sel, data: data};
    @(posedge ref_clk_i);
  endtask
  // A released bus shows inverted data so a stale byte is never reused.
  task automatic idle();
    @(negedge ref_clk_i);
    host_o.wr   = 1'b0;
    host_o.data = ~host_o.data;
  endtask
endmodule

/* testbench/tb.sv */
// Self-checking testbench for the power, scan and clock command decoder.
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb;
  import opsc_pkg::*;
  localparam int OSC = 2;
  logic              ref_clk_i = 1'b0;
  logic              rst_b_i   = 1'b0;
  logic [OFFS_W-1:0] mux_last  = 6'h3f;
  opsc_host_t        host_bus;
  opsc_cfg_t         cfg;
  logic [PAGE_W-1:0] page;
  logic              sleep, pump_run, ext_req, osc_run, oe_b, tick, undef;
  logic [OFFS_W-1:0] first_row, com_row, disp_line;
  logic              frame, taken;
  int                fail_count = 0;
  int                total_checks = 0;
  int                undef_seen = 0;
  int                taken_seen = 0;
  // ----------------------------------------------------------------------
  // Clock, instances and closing
  // ----------------------------------------------------------------------
  always #25 ref_clk_i = ~ref_clk_i;
  // Pulses are counted mid-cycle, away from the edge that launches them.
  always @(negedge ref_clk_i) if (undef === 1'b1) undef_seen++;
  always @(negedge ref_clk_i) if (taken === 1'b1) taken_seen++;
  opsc_host_model hm (.ref_clk_i(ref_clk_i), .host_o(host_bus));
  opsc_top #(.OSC_CYCLES(OSC), .CLKS_PER_ROW(4)) uut (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .host_i(host_bus),
    .mux_last_i(mux_last), .cfg_o(cfg), .page_o(page), .mem_wr_o(),
    .mem_wdata_o(), .sleep_o(sleep), .pump_run_o(pump_run),
    .ext_supply_req_o(ext_req), .osc_run_o(osc_run), .panel_oe_b_o(oe_b),
    .display_clock_tick_o(tick), .first_common_row_o(first_row),
    .common_row_o(com_row), .display_line_o(disp_line), .frame_start_o(frame),
    .cmd_taken_o(taken), .cmd_undef_o(undef));
  task automatic tally_and_finish();
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic put(input logic [7:0] d);
    hm.send(1'b0, d);
    hm.idle();
    cyc(2);
  endtask
  task automatic t_power();
    hm.send(1'b0, 8'had);
    hm.send(1'b0, 8'h8a);
    hm.idle();
    cyc(2);
    `CHK("pump_armed", 1'b0, cfg.pump_armed)
    put(8'haf);
    `CHK("ext_on", 3'b010, {sleep, ext_req, pump_run})
    put(8'hae);
    `CHK("off", 4'b1001, {sleep, osc_run, pump_run, oe_b})
    `CHK("kept_pump", 1'b0, cfg.pump_armed)
    hm.send(1'b0, 8'had);
    hm.send(1'b0, 8'h8b);
    hm.idle();
    put(8'haf);
    `CHK("on", 5'b01100, {sleep, osc_run, pump_run, oe_b, ext_req})
  endtask
  task automatic t_clock();
    logic [7:0] arg [2];
    int         n;
    int         e;
    int         fr;
    arg = '{8'h53, 8'hf0};
    for (int i = 0; i < 2; i++) begin
      hm.send(1'b0, 8'hd5);
      hm.send(1'b0, arg[i]);
      hm.idle();
      cyc(4);
      `CHK("div", arg[i][3:0], cfg.div_nib)
      `CHK("trim", arg[i][7:4], cfg.trim)
      e = 800 * (TRIM_BASE + arg[i][7:4]) /
          (TRIM_DEN * OSC * (arg[i][3:0] + 1));
      n = 0;
      fr = 0;
      repeat (800) begin
        @(negedge ref_clk_i);
        if (tick === 1'b1) n++;
        if (frame === 1'b1) fr++;
      end
      `CHK("ticks", 1'b1, (n >= e - 1 && n <= e + 1))
      `CHK("frames", 1'b1, (fr >= (e-1)/256 && fr <= (e+1)/256 + 1))
    end
  endtask
  task automatic t_scan_offset();
    put(8'hc8);
    `CHK("scan_c8", 1'b1, cfg.scan_rev)
    put(8'hc0);
    `CHK("scan_c0", 1'b0, cfg.scan_rev)
    `CHK("rows_fwd", disp_line, com_row)
    put(8'hc4);
    `CHK("scan_c4", 1'b0, cfg.scan_rev)
    put(8'hcf);
    `CHK("scan_cf", 1'b1, cfg.scan_rev)
    hm.send(1'b0, 8'hd3);
    hm.send(1'b1, 8'h5a);
    hm.send(1'b0, 8'he5);
    hm.idle();
    cyc(2);
    `CHK("offset", 12'h965, {cfg.offset, first_row})
    `CHK("rows_rev", 6'h25, 6'(6'h3f - com_row - disp_line))
  endtask
  task automatic t_page();
    put(8'hae);
    for (int i = 0; i < 8; i++) begin
      put(8'hb7 - 8'(i));
      `CHK("page", 3'(7 - i), page)
    end
    hm.send(1'b1, 8'h3c);
    hm.idle();
    cyc(2);
    `CHK("kept", {3'b101, 6'h25, 4'h0, 4'hf}, cfg)
  endtask
  task automatic t_refuse();
    int n;
    int m;
    n = undef_seen;
    m = taken_seen;
    hm.send(1'b0, 8'had);
    hm.send(1'b0, 8'haf);
    hm.send(1'b0, 8'hff);
    hm.idle();
    cyc(2);
    `CHK("refused", 1'b0, cfg.disp_on)
    `CHK("undef", n + 2, undef_seen)
    `CHK("taken", m + 3, taken_seen)
  endtask
  initial begin
    cyc(8);
    rst_b_i = 1'b1;
    cyc(1);
    `CHK("cfg_rst", {3'b100, 6'h00, 4'h0, 4'h5}, cfg)
    `CHK("rst_out", 5'b11000, {sleep, oe_b, page})
    t_power();
    t_clock();
    t_scan_offset();
    t_page();
    t_refuse();
    tally_and_finish();
  end
  initial begin
    repeat (10000) @(posedge ref_clk_i);
    fail_count++;
    tally_and_finish();
  end
endmodule
